// [hdl/epcirq_sync.sv]
`default_nettype none
// two-stage synchroniser for a bundle of pins
module epcirq_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] stable_q;

  // first stage feeds only the second
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      meta_q <= '0;
      stable_q <= '0;
    end else begin
      meta_q <= async_in;
      stable_q <= meta_q;
    end
  end

  assign sync_out = stable_q;

endmodule
`default_nettype wire

// [hdl/epcirq_unit.sv]
// How it works
// - line 0 requests only with its enable bit and global enable both set
// - dedicated lines sense the pin itself, so driving it as output triggers
// - sense code: 00 low level, 01 any change, 10 falling, 11 rising
// - a triggering edge or change on a line sets that line's flag
// - flagged, enabled line vectors to core; flag clears when handler runs
// - writing one to a flag bit clears it; zero leaves it alone
// - a line in low-level sensing always reads its flag as zero
// - external flags at data 0x3C and i/o 0x1C; i/o is data minus 0x20
// - group 2 enable plus global lets unmasked inputs 23..16 interrupt
// - group 1 and 0 enables cover inputs 14..8 and 7..0 likewise
// - any logic change on an active group pin sets that group's flag
// - flagged, enabled group vectors to core; flag clears when handler runs
// - group 0 mask bit enables its pin only while group enable is set
// - group 1 mask has seven bits 6..0 for inputs 8..14, bit 7 absent
// - group 2 mask bit n enables input 16+n while group 2 enabled
// - pin changes are seen without the clock to wake from deep sleep
`default_nettype none
module epcirq_unit #(
  parameter int PINS = 24
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire epcirq_pkg::epcirq_ds_bus_t ds_bus,
  output logic [7:0] ds_rdata,
  input wire epcirq_pkg::epcirq_io_bus_t io_bus,
  output logic [7:0] io_rdata,
  input wire logic [1:0] ext_line_pin,
  input wire logic [PINS-1:0] change_sensed_input,
  input wire logic global_irq_enable,
  input wire logic [epcirq_pkg::NUM_REQ-1:0] vector_ack,
  output logic [epcirq_pkg::NUM_REQ-1:0] irq_request,
  output logic wake_request
);

  // stored registers
  logic [1:0] ext_flags_q;
  logic [1:0] ext_flags_d;
  logic [1:0] ext_en_q;
  logic [3:0] sense_cfg_q;
  logic [2:0] pc_flags_q;
  logic [2:0] pc_flags_d;
  logic [2:0] pc_en_q;
  logic [7:0] pc_mask0_q;
  logic [6:0] pc_mask1_q;
  logic [7:0] pc_mask2_q;

  // pin history
  logic [PINS+1:0] pins_s;
  logic [PINS+1:0] pins_q;
  logic [epcirq_pkg::SETTLE_CYCLES-1:0] settle_q;
  logic history_ok;

  // merged write port
  logic wr_en;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic [7:0] io_as_ds;

  // one write strobe per register
  logic wr_ext_flags;
  logic wr_ext_en;
  logic wr_sense;
  logic wr_pc_flags;
  logic wr_pc_en;
  logic wr_mask0;
  logic wr_mask1;
  logic wr_mask2;

  // per-source events
  logic [1:0] line_now;
  logic [1:0] line_prev;
  logic [1:0] line_level;
  logic [1:0] line_low;
  logic [1:0] ext_set;
  logic [1:0] ext_clr;
  logic [PINS-1:0] pin_change;
  logic [2:0] pc_set;
  logic [2:0] pc_clr;
  logic [1:0] ext_wake;
  logic [PINS-1:0] raw_change;
  logic [2:0] pc_wake;

  // sense field of line n
  function automatic epcirq_pkg::epcirq_sense_t line_sense(
    input logic [3:0] cfg,
    input int n
  );
    logic [1:0] code;
    code = (n == 0) ? cfg[epcirq_pkg::LINE0_SENSE_LSB +: 2] : cfg[epcirq_pkg::LINE1_SENSE_LSB +: 2];
    return epcirq_pkg::epcirq_sense_t'(code);
  endfunction

  // edge decision of a dedicated line, level mode raises no event
  function automatic logic line_event(
    input epcirq_pkg::epcirq_sense_t sense,
    input logic now,
    input logic prev
  );
    logic hit;
    hit = 1'b0;
    unique case (sense)
      epcirq_pkg::EPCIRQ_SENSE_LOW: hit = 1'b0;
      epcirq_pkg::EPCIRQ_SENSE_ANY: hit = now ^ prev;
      epcirq_pkg::EPCIRQ_SENSE_FALL: hit = prev & ~now;
      epcirq_pkg::EPCIRQ_SENSE_RISE: hit = ~prev & now;
    endcase
    return hit;
  endfunction

  // any change on an unmasked pin of an enabled group
  function automatic logic group_hit(
    input logic enable,
    input logic [7:0] change,
    input logic [7:0] mask
  );
    return enable & (|(change & mask));
  endfunction

  // write strobe of the register at one offset
  function automatic logic write_hits(
    input logic en,
    input logic [7:0] addr,
    input logic [7:0] ofs
  );
    return en & (addr == ofs);
  endfunction

  // register readback, unmapped and reserved bits read zero
  function automatic logic [7:0] read_reg(
    input logic [7:0] addr,
    input logic [1:0] ext_flags,
    input logic [1:0] ext_en,
    input logic [3:0] sense,
    input logic [2:0] pc_flags,
    input logic [2:0] pc_en,
    input logic [7:0] mask0,
    input logic [6:0] mask1,
    input logic [7:0] mask2
  );
    logic [7:0] data;
    data = 8'h00;
    unique case (addr)
      epcirq_pkg::EXT_FLAGS_OFS: data = {6'b00_0000, ext_flags};
      epcirq_pkg::EXT_EN_OFS: data = {6'b00_0000, ext_en};
      epcirq_pkg::SENSE_CFG_OFS: data = {4'h0, sense};
      epcirq_pkg::PC_FLAGS_OFS: data = {5'b0_0000, pc_flags};
      epcirq_pkg::PC_EN_OFS: data = {5'b0_0000, pc_en};
      epcirq_pkg::PC_MASK0_OFS: data = mask0;
      epcirq_pkg::PC_MASK1_OFS: data = {1'b0, mask1};
      epcirq_pkg::PC_MASK2_OFS: data = mask2;
      default: data = 8'h00;
    endcase
    return data;
  endfunction

  // pins cross into the clock domain before any edge logic
  epcirq_sync #(
    .WIDTH(PINS + 2)
  ) u_pin_sync (
    .clock(clock),
    .rst_b(rst_b),
    .async_in({ext_line_pin, change_sensed_input}),
    .sync_out(pins_s)
  );

  // previous sample of every synchronised pin
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pins_q <= '0;
    end else begin
      pins_q <= pins_s;
    end
  end

  // hold off edges until the synchroniser holds real pin values
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      settle_q <= '0;
    end else begin
      settle_q <= {settle_q[epcirq_pkg::SETTLE_CYCLES-2:0], 1'b1};
    end
  end

  assign history_ok = settle_q[epcirq_pkg::SETTLE_CYCLES-1];

  // i/o address maps onto data space
  assign io_as_ds = 8'({2'b00, io_bus.addr}) + epcirq_pkg::IO_SPACE_BASE;

  // data-space access wins if both ports write together
  always_comb begin
    wr_en = 1'b0;
    wr_addr = 8'h00;
    wr_data = 8'h00;
    if (ds_bus.we) begin
      wr_en = 1'b1;
      wr_addr = ds_bus.addr;
      wr_data = ds_bus.wdata;
    end else if (io_bus.we) begin
      wr_en = 1'b1;
      wr_addr = io_as_ds;
      wr_data = io_bus.wdata;
    end
  end

  // merged write port decoded once per register
  assign wr_ext_flags = write_hits(wr_en, wr_addr, epcirq_pkg::EXT_FLAGS_OFS);
  assign wr_ext_en = write_hits(wr_en, wr_addr, epcirq_pkg::EXT_EN_OFS);
  assign wr_sense = write_hits(wr_en, wr_addr, epcirq_pkg::SENSE_CFG_OFS);
  assign wr_pc_flags = write_hits(wr_en, wr_addr, epcirq_pkg::PC_FLAGS_OFS);
  assign wr_pc_en = write_hits(wr_en, wr_addr, epcirq_pkg::PC_EN_OFS);
  assign wr_mask0 = write_hits(wr_en, wr_addr, epcirq_pkg::PC_MASK0_OFS);
  assign wr_mask1 = write_hits(wr_en, wr_addr, epcirq_pkg::PC_MASK1_OFS);
  assign wr_mask2 = write_hits(wr_en, wr_addr, epcirq_pkg::PC_MASK2_OFS);

  // plain read/write control registers
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ext_en_q <= epcirq_pkg::REG_RESET[1:0];
      sense_cfg_q <= epcirq_pkg::REG_RESET[3:0];
      pc_en_q <= epcirq_pkg::REG_RESET[2:0];
      pc_mask0_q <= epcirq_pkg::REG_RESET;
      pc_mask1_q <= epcirq_pkg::REG_RESET[6:0];
      pc_mask2_q <= epcirq_pkg::REG_RESET;
    end else begin
      if (wr_ext_en) begin
        ext_en_q <= wr_data[1:0] & epcirq_pkg::EXT_IMPL[1:0];
      end
      if (wr_sense) begin
        sense_cfg_q <= wr_data[3:0] & epcirq_pkg::SENSE_IMPL[3:0];
      end
      if (wr_pc_en) begin
        pc_en_q <= wr_data[2:0] & epcirq_pkg::PC_IMPL[2:0];
      end
      if (wr_mask0) begin
        pc_mask0_q <= wr_data;
      end
      if (wr_mask1) begin
        pc_mask1_q <= wr_data[6:0] & epcirq_pkg::MASK1_IMPL[6:0];
      end
      if (wr_mask2) begin
        pc_mask2_q <= wr_data;
      end
    end
  end

  // dedicated line sampling, pin value seen regardless of direction
  assign line_now = pins_s[PINS+1:PINS];
  assign line_prev = pins_q[PINS+1:PINS];

  // per-line trigger, level and clear terms
  always_comb begin
    for (int n = 0; n < 2; n++) begin
      line_level[n] = line_sense(sense_cfg_q, n) == epcirq_pkg::EPCIRQ_SENSE_LOW;
      line_low[n] = line_level[n] & ~line_now[n];
      ext_set[n] = history_ok & line_event(line_sense(sense_cfg_q, n), line_now[n], line_prev[n]);
      ext_clr[n] = (wr_ext_flags & wr_data[n])
        | vector_ack[epcirq_pkg::REQ_LINE0 + n];
    end
  end

  // set beats clear, level mode pins flag at zero
  always_comb begin
    for (int n = 0; n < 2; n++) begin
      if (line_level[n]) begin
        ext_flags_d[n] = 1'b0;
      end else begin
        ext_flags_d[n] = ext_set[n] | (ext_flags_q[n] & ~ext_clr[n]);
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ext_flags_q <= epcirq_pkg::REG_RESET[1:0];
    end else begin
      ext_flags_q <= ext_flags_d;
    end
  end

  // changes seen on each change-sensed input
  assign pin_change = history_ok ? (pins_s[PINS-1:0] ^ pins_q[PINS-1:0]) : '0;

  // group triggers gated by mask and group enable
  always_comb begin
    pc_set[0] = group_hit(pc_en_q[0], pin_change[7:0], pc_mask0_q);
    pc_set[1] = group_hit(pc_en_q[1], {1'b0, pin_change[epcirq_pkg::GRP1_FIRST_PIN +: epcirq_pkg::GRP1_PINS]},
      {1'b0, pc_mask1_q});
    pc_set[2] = group_hit(pc_en_q[2], pin_change[epcirq_pkg::GRP2_FIRST_PIN +: 8], pc_mask2_q);
    for (int g = 0; g < 3; g++) begin
      pc_clr[g] = (wr_pc_flags & wr_data[g])
        | vector_ack[epcirq_pkg::REQ_GRP0 + g];
    end
  end

  // group flags, a new change outranks a clear
  assign pc_flags_d = pc_set | (pc_flags_q & ~pc_clr);

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pc_flags_q <= epcirq_pkg::REG_RESET[2:0];
    end else begin
      pc_flags_q <= pc_flags_d;
    end
  end

  // separate vectored requests, each gated by its enable and global enable
  always_comb begin
    irq_request = '0;
    for (int n = 0; n < 2; n++) begin
      irq_request[epcirq_pkg::REQ_LINE0 + n] = global_irq_enable & ext_en_q[n]
        & (ext_flags_q[n] | line_low[n]);
    end
    for (int g = 0; g < 3; g++) begin
      irq_request[epcirq_pkg::REQ_GRP0 + g] = global_irq_enable & pc_en_q[g] & pc_flags_q[g];
    end
  end

  // clockless wake path for sleep with the i/o clock stopped
  always_comb begin
    for (int n = 0; n < 2; n++) begin
      ext_wake[n] = ext_en_q[n] & line_level[n] & ~ext_line_pin[n];
    end
    raw_change = change_sensed_input ^ pins_q[PINS-1:0];
    pc_wake[0] = group_hit(pc_en_q[0], raw_change[7:0], pc_mask0_q);
    pc_wake[1] = group_hit(pc_en_q[1], {1'b0, raw_change[epcirq_pkg::GRP1_FIRST_PIN +: epcirq_pkg::GRP1_PINS]},
      {1'b0, pc_mask1_q});
    pc_wake[2] = group_hit(pc_en_q[2], raw_change[epcirq_pkg::GRP2_FIRST_PIN +: 8], pc_mask2_q);
  end

  assign wake_request = (|ext_wake) | (|pc_wake) | (|irq_request);

  // registered readback on each port, flags of level lines read zero
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ds_rdata <= 8'h00;
      io_rdata <= 8'h00;
    end else begin
      ds_rdata <= ds_bus.re ? read_reg(ds_bus.addr, ext_flags_q & ~line_level, ext_en_q, sense_cfg_q,
        pc_flags_q, pc_en_q, pc_mask0_q, pc_mask1_q, pc_mask2_q) : 8'h00;
      io_rdata <= io_bus.re ? read_reg(io_as_ds, ext_flags_q & ~line_level, ext_en_q, sense_cfg_q,
        pc_flags_q, pc_en_q, pc_mask0_q, pc_mask1_q, pc_mask2_q) : 8'h00;
    end
  end

endmodule
`default_nettype wire

// [shared/epcirq_pkg.sv]
`default_nettype none
package epcirq_pkg;

  // register offsets in data space
  localparam logic [7:0] PC_FLAGS_OFS = 8'h3b;
  localparam logic [7:0] EXT_FLAGS_OFS = 8'h3c;
  localparam logic [7:0] EXT_EN_OFS = 8'h3d;
  localparam logic [7:0] PC_EN_OFS = 8'h68;
  localparam logic [7:0] SENSE_CFG_OFS = 8'h69;
  localparam logic [7:0] PC_MASK0_OFS = 8'h6b;
  localparam logic [7:0] PC_MASK1_OFS = 8'h6c;
  localparam logic [7:0] PC_MASK2_OFS = 8'h6d;

  // i/o instruction space sits this far below data space
  localparam logic [7:0] IO_SPACE_BASE = 8'h20;

  // reset value of every register
  localparam logic [7:0] REG_RESET = 8'h00;

  // implemented bits per register
  localparam logic [7:0] EXT_IMPL = 8'h03;
  localparam logic [7:0] PC_IMPL = 8'h07;
  localparam logic [7:0] SENSE_IMPL = 8'h0f;
  localparam logic [7:0] MASK1_IMPL = 8'h7f;

  // field positions
  localparam int LINE0_SENSE_LSB = 0;
  localparam int LINE1_SENSE_LSB = 2;
  localparam int GRP1_FIRST_PIN = 8;
  localparam int GRP1_PINS = 7;
  localparam int GRP2_FIRST_PIN = 16;

  // request vector positions, lowest index is highest core priority
  localparam int REQ_LINE0 = 0;
  localparam int REQ_LINE1 = 1;
  localparam int REQ_GRP0 = 2;
  localparam int REQ_GRP1 = 3;
  localparam int REQ_GRP2 = 4;
  localparam int NUM_REQ = 5;

  // cycles after reset release before edge history is trusted
  localparam int SETTLE_CYCLES = 3;

  // sense control codes of a dedicated line
  typedef enum logic [1:0] {
    EPCIRQ_SENSE_LOW = 2'b00,
    EPCIRQ_SENSE_ANY = 2'b01,
    EPCIRQ_SENSE_FALL = 2'b10,
    EPCIRQ_SENSE_RISE = 2'b11
  } epcirq_sense_t;

  // data-space access port
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic we;
    logic re;
  } epcirq_ds_bus_t;

  // i/o instruction access port
  typedef struct packed {
    logic [5:0] addr;
    logic [7:0] wdata;
    logic we;
    logic re;
  } epcirq_io_bus_t;

endpackage
`default_nettype wire

// [test/epcirq_core_model.sv]
`default_nettype none
// core side: takes the lowest pending request after a short or long delay
module epcirq_core_model (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic ack_on,
  input wire logic slow,
  input wire logic [epcirq_pkg::NUM_REQ-1:0] irq_request,
  output logic [epcirq_pkg::NUM_REQ-1:0] vector_ack
);
  logic [2:0] hold_q;
  // one ack pulse per handler, lowest index first
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      hold_q <= 3'h0;
      vector_ack <= '0;
    end else begin
      vector_ack <= '0;
      if (!ack_on || irq_request == '0 || vector_ack != '0) begin
        hold_q <= 3'h0;
      end else if (hold_q == (slow ? 3'h5 : 3'h1)) begin
        vector_ack <= irq_request & (~irq_request + 5'h01);
        hold_q <= 3'h0;
      end else begin
        hold_q <= hold_q + 3'h1;
      end
    end
  end
endmodule
`default_nettype wire

// [test/epcirq_unit_chk.sv]
`default_nettype none
module epcirq_unit_chk #(
  parameter int PINS = 24
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire epcirq_pkg::epcirq_ds_bus_t ds_bus,
  input wire logic [7:0] ds_rdata,
  input wire epcirq_pkg::epcirq_io_bus_t io_bus,
  input wire logic [7:0] io_rdata,
  input wire logic [PINS-1:0] change_sensed_input,
  input wire logic global_irq_enable,
  input wire logic [epcirq_pkg::NUM_REQ-1:0] vector_ack,
  input wire logic [epcirq_pkg::NUM_REQ-1:0] irq_request
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  // no pin set can still be in flight
  sequence s_quiet;
    $stable(change_sensed_input) [*4];
  endsequence
  property p_glob_gate;
    !global_irq_enable |-> irq_request == '0;
  endproperty
  property p_ack_clr;
    s_quiet ##0 vector_ack[2] |=> !irq_request[2];
  endproperty
  property p_w1c;
    s_quiet ##0 (ds_bus.we && ds_bus.addr == 8'h3b && ds_bus.wdata[0]) |=> !irq_request[2];
  endproperty
  property p_stand;
    irq_request[2] && !vector_ack[2] && !ds_bus.we && !io_bus.we |=> irq_request[2] || !global_irq_enable;
  endproperty
  property p_rd_idle;
    !ds_bus.re |=> ds_rdata == 8'h00;
  endproperty
  property p_io_idle;
    !io_bus.re |=> io_rdata == 8'h00;
  endproperty
  property p_ext_rsvd;
    io_bus.re && io_bus.addr == 6'h1c |=> io_rdata[7:2] == 6'h00;
  endproperty
  property p_pc_rsvd;
    ds_bus.re && ds_bus.addr == 8'h3b |=> ds_rdata[7:3] == 5'h00;
  endproperty
  property p_mask1_rsvd;
    ds_bus.re && ds_bus.addr == 8'h6c |=> !ds_rdata[7];
  endproperty
  a_glob_gate: assert property (p_glob_gate) else $error("request without global enable");
  a_ack_clr: assert property (p_ack_clr) else $error("ack left group0 pending");
  a_w1c: assert property (p_w1c) else $error("flag write of one did not clear");
  a_stand: assert property (p_stand) else $error("group0 request dropped by itself");
  a_rd_idle: assert property (p_rd_idle) else $error("data read bus not idle");
  a_io_idle: assert property (p_io_idle) else $error("io read bus not idle");
  a_ext_rsvd: assert property (p_ext_rsvd) else $error("line flag spare bits set");
  a_pc_rsvd: assert property (p_pc_rsvd) else $error("group flag spare bits set");
  a_mask1_rsvd: assert property (p_mask1_rsvd) else $error("mask1 top bit set");
endmodule
bind epcirq_unit epcirq_unit_chk #(.PINS(PINS)) u_chk (.clock(clock), .rst_b(rst_b), .ds_bus(ds_bus),
  .ds_rdata(ds_rdata), .io_bus(io_bus), .io_rdata(io_rdata), .change_sensed_input(change_sensed_input),
  .global_irq_enable(global_irq_enable), .vector_ack(vector_ack), .irq_request(irq_request));
`default_nettype wire

// [test/ext_pin_change_irq_unit_bench.sv]
`default_nettype none
module ext_pin_change_irq_unit_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, rst_b, global_irq_enable, wake_request, ack_on, slow;
  epcirq_pkg::epcirq_ds_bus_t ds_bus;
  epcirq_pkg::epcirq_io_bus_t io_bus;
  logic [7:0] ds_rdata, io_rdata, got;
  logic [1:0] ext_line_pin;
  logic [23:0] change_sensed_input;
  logic [4:0] vector_ack, irq_request;
  int err_total, checks;
  epcirq_unit #(.PINS(24)) u_dut (.clock(clock), .rst_b(rst_b), .ds_bus(ds_bus), .ds_rdata(ds_rdata),
    .io_bus(io_bus), .io_rdata(io_rdata), .ext_line_pin(ext_line_pin), .change_sensed_input(change_sensed_input),
    .global_irq_enable(global_irq_enable), .vector_ack(vector_ack), .irq_request(irq_request),
    .wake_request(wake_request));
  epcirq_core_model u_core (.clock(clock), .rst_b(rst_b), .ack_on(ack_on), .slow(slow),
    .irq_request(irq_request), .vector_ack(vector_ack));
  // free-running clock
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude;
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // one register access on the data or io port
  task automatic acc(input bit io, input bit w, input logic [7:0] a, input logic [7:0] d);
    logic [7:0] ia;
    ia = a - epcirq_pkg::IO_SPACE_BASE;
    @(posedge clock);
    if (io) io_bus <= '{addr: ia[5:0], wdata: d, we: w, re: !w};
    else ds_bus <= '{addr: a, wdata: d, we: w, re: !w};
    @(posedge clock);
    io_bus <= '0;
    ds_bus <= '0;
    #1 got = io ? io_rdata : ds_rdata;
  endtask
  // pin moves are held well over one clock
  task automatic pc(input int n);
    @(posedge clock);
    change_sensed_input[n] <= !change_sensed_input[n];
    repeat (6) @(posedge clock);
    #1;
  endtask
  task automatic line(input int l, input logic v);
    @(posedge clock);
    ext_line_pin[l] <= v;
    repeat (6) @(posedge clock);
    #1;
  endtask
  // reset values, implemented bits, unmapped place
  task automatic t_regs;
    logic [7:0] ofs [8] = '{8'h3b, 8'h3c, 8'h3d, 8'h68, 8'h69, 8'h6b, 8'h6c, 8'h6d};
    logic [7:0] imp [8] = '{8'h07, 8'h03, 8'h03, 8'h07, 8'h0f, 8'hff, 8'h7f, 8'hff};
    chk(8'(wake_request), 8'h00);
    for (int i = 0; i < 8; i++) begin
      acc(0, 0, ofs[i], 8'h00);
      chk(got, 8'h00);
      if (i > 1) begin
        acc(0, 1, ofs[i], 8'hff);
        acc(0, 0, ofs[i], 8'h00);
        chk(got, imp[i]);
        acc(0, 1, ofs[i], 8'h00);
      end
    end
    acc(0, 1, 8'h70, 8'hff);
    acc(0, 0, 8'h70, 8'h00);
    chk(got, 8'h00);
  endtask
  // each group: mask and enable gating, flag, clear
  task automatic t_groups;
    int pin [3] = '{0, 8, 16};
    for (int g = 0; g < 3; g++) begin
      acc(0, 1, 8'h6b + 8'(g), 8'h01);
      pc(pin[g]);
      acc(0, 0, 8'h3b, 8'h00);
      chk(got, 8'h00);
      acc(0, 1, 8'h68, 8'h01 << g);
      pc(pin[g] + 1);
      chk(8'(irq_request), 8'h00);
      pc(pin[g]);
      chk(8'(irq_request), 8'h04 << g);
      acc(1, 1, 8'h3b, 8'h00);
      acc(0, 0, 8'h3b, 8'h00);
      chk(got, 8'h01 << g);
      acc(0, 1, 8'h3b, 8'h01 << g);
      acc(1, 0, 8'h3b, 8'h00);
      chk(got, 8'h00);
      acc(0, 1, 8'h68, 8'h00);
      acc(0, 1, 8'h6b + 8'(g), 8'h00);
    end
  endtask
  // every sense code on both dedicated lines
  task automatic t_ext;
    for (int l = 0; l < 2; l++) begin
      for (int c = 0; c < 4; c++) begin
        acc(0, 1, 8'h69, 8'(c << (2 * l)));
        acc(0, 1, 8'h3d, 8'h01 << l);
        line(l, 1'b1);
        acc(1, 0, 8'h3c, 8'h00);
        chk(got, (c == 1 || c == 3) ? 8'h01 << l : 8'h00);
        acc(0, 1, 8'h3c, 8'h03);
        line(l, 1'b0);
        chk(8'(irq_request), (c != 3) ? 8'h01 << l : 8'h00);
        chk(8'(wake_request), (c != 3) ? 8'h01 : 8'h00);
        acc(1, 0, 8'h3c, 8'h00);
        chk(got, (c == 1 || c == 2) ? 8'h01 << l : 8'h00);
        acc(0, 1, 8'h3c, 8'h03);
        acc(0, 1, 8'h3d, 8'h00);
      end
    end
  endtask
  // request waits for the global enable, flag already set
  task automatic t_glob;
    @(posedge clock) global_irq_enable <= 1'b0;
    acc(0, 1, 8'h69, 8'h03);
    acc(0, 1, 8'h3d, 8'h01);
    line(0, 1'b1);
    chk(8'(irq_request), 8'h00);
    @(posedge clock) global_irq_enable <= 1'b1;
    #1 chk(8'(irq_request), 8'h01);
    ack_on <= 1'b1;
    repeat (8) @(posedge clock);
    acc(0, 0, 8'h3c, 8'h00);
    chk(got, 8'h00);
    line(0, 1'b0);
    acc(0, 1, 8'h3d, 8'h00);
  endtask
  // core acks promptly and slowly
  task automatic t_ack;
    acc(0, 1, 8'h68, 8'h01);
    acc(0, 1, 8'h6b, 8'h01);
    for (int s = 0; s < 2; s++) begin
      @(posedge clock) slow <= s[0];
      pc(0);
      if (s == 1) chk(8'(irq_request), 8'h04);
      repeat (8) @(posedge clock);
      acc(0, 0, 8'h3b, 8'h00);
      chk(got, 8'h00);
    end
  endtask
  // mid-run reset clears a pending flag, enables and masks
  task automatic t_rst;
    @(posedge clock) ack_on <= 1'b0;
    acc(0, 1, 8'h6b, 8'h08);
    pc(3);
    chk(8'(irq_request), 8'h04);
    @(posedge clock) rst_b <= 1'b0;
    repeat (2) @(posedge clock);
    #1 chk(8'(irq_request), 8'h00);
    @(posedge clock) rst_b <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      acc(0, 0, (i == 0) ? 8'h3b : ((i == 1) ? 8'h68 : 8'h6b), 8'h00);
      chk(got, 8'h00);
    end
    pc(3);
    chk(8'(irq_request), 8'h00);
  endtask
  initial begin
    ds_bus = '0;
    io_bus = '0;
    ext_line_pin = 2'h0;
    change_sensed_input = 24'h00_0000;
    global_irq_enable = 1'b0;
    ack_on = 1'b0;
    slow = 1'b0;
    err_total = 0;
    checks = 0;
    rst_b = 1'b0;
    repeat (12) @(posedge clock);
    rst_b <= 1'b1;
    repeat (4) @(posedge clock);
    t_regs;
    @(posedge clock) global_irq_enable <= 1'b1;
    t_groups;
    t_ext;
    t_glob;
    t_ack;
    t_rst;
    conclude;
  end
  // hang guard
  initial begin
    repeat (20000) @(posedge clock);
    err_total++;
    conclude;
  end
endmodule
`default_nettype wire
